// ===== design/gmo_depth.sv
// depth buffer word decoder
`timescale 1ns/1ps
`default_nettype none
`include "gmo_defines.svh"
module gmo_depth (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // raw word and format
  input  wire logic [1:0]  i_fmt,
  input  wire logic [63:0] i_word,
  // decoded value
  output logic [31:0]      o_depth,
  output logic             o_is_float,
  output logic [7:0]       o_stencil,
  output logic             o_has_stencil
);
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_depth       <= 32'h0;
      o_is_float    <= 1'b0;
      o_stencil     <= 8'h0;
      o_has_stencil <= 1'b0;
    end else begin
      o_is_float    <= (i_fmt == `GMO_DF_F32_S8_64) || (i_fmt == `GMO_DF_F32);
      o_has_stencil <= (i_fmt == `GMO_DF_F32_S8_64) || (i_fmt == `GMO_DF_U24_S8);
      unique case (i_fmt)
        `GMO_DF_F32_S8_64: begin
          o_depth   <= i_word[31:0];
          o_stencil <= i_word[63:56];
        end
        `GMO_DF_F32: begin
          o_depth   <= i_word[31:0];
          o_stencil <= 8'h0;
        end
        `GMO_DF_U24_S8: begin
          o_depth   <= {8'h0, i_word[23:0]};
          o_stencil <= i_word[31:24];
        end
        `GMO_DF_U16: begin
          o_depth   <= {16'h0, i_word[15:0]};
          o_stencil <= 8'h0;
        end
      endcase
    end
  end

  d24_split_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_fmt == `GMO_DF_U24_S8) |=> (o_depth == {8'h0, $past(i_word[23:0])} &&
      o_stencil == $past(i_word[31:24]) && o_has_stencil))
    else $error("packed depth split wrong");
  // stencil from top byte of second word
  d64_split_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_fmt == `GMO_DF_F32_S8_64) |=> (o_stencil == $past(i_word[63:56]) &&
      o_depth == $past(i_word[31:0]) && o_is_float))
    else $error("64-bit depth split wrong");
endmodule
`default_nettype wire

// ===== design/gmo_top.sv
// graphics memory object placement, checking and translation
//
// Notes on behaviour
// - addresses translate through 32-bit entries held in memory tables
// - global table is 128KB, 256KB or 512KB for 128MB to 512MB apertures
// - per-process table may also be 64KB, a 64MB aperture
// - status reports are master writes into an aligned snooped 4KB page
// - ring length is capped at 2MB
// - batch end address names the last word, fetched inclusively
// - batch fetches never snoop the processor cache
// - batch buffers may span up to 4GB
// - 64-bit depth: float depth low word, stencil top byte of high word
// - 32-bit depth-stencil: 24-bit depth low, stencil high byte
// - float32 and unorm16 depth-only formats carry no stencil
// - colour buffer always required for o_pipe_ok, but flagged missing only with depth or stencil tests; depth buffer needed for depth tests
`timescale 1ns/1ps
`default_nettype none
`include "gmo_defines.svh"
module gmo_top import gmo_pkg::*; (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // avalon-mm register slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // translation requests from memory clients
  input  wire logic        i_xl_req,
  input  wire logic [31:0] i_xl_laddr,
  output logic             o_xl_ack,
  output logic [31:0]      o_xl_paddr,
  output logic             o_xl_err,
  // table entry fetch, never snooped
  output logic             o_pte_rd,
  output logic [31:0]      o_pte_addr,
  output logic             o_pte_snoop,
  input  wire logic        i_pte_wait,
  input  wire logic [31:0] i_pte_rdata,
  // batch buffer fetch
  output logic             o_batch_valid,
  output logic [31:0]      o_batch_addr,
  output logic             o_batch_snoop,
  input  wire logic        i_batch_ready,
  // status page master write
  output logic             o_hws_wr,
  output logic [31:0]      o_hws_addr,
  output logic [31:0]      o_hws_data,
  output logic             o_hws_snoop,
  input  wire logic        i_hws_wait,
  // depth buffer word decode
  input  wire logic [63:0] i_depth_word,
  output logic [31:0]      o_depth,
  output logic             o_depth_is_float,
  output logic [7:0]       o_stencil,
  output logic             o_has_stencil,
  // pipeline buffer state
  output logic             o_pipe_ok
);
  // ==========================================================
  // bus access
  // ==========================================================
  logic        ack_reg;
  logic        req;
  logic        wr_take;
  logic [31:0] wmerge;
  logic [31:0] global_ctl_reg;
  logic [31:0] pproc_ctl_reg;
  logic [31:0] status_page_reg;
  logic [31:0] ring_start_reg;
  logic [31:0] ring_len_reg;
  logic [31:0] batch_start_reg;
  logic [31:0] batch_end_reg;
  logic [31:0] depth_cfg_reg;
  logic [`GMO_ERR_W-1:0] err_reg;
  logic [`GMO_ERR_W-1:0] err_set;
  logic [`GMO_ERR_W-1:0] err_clr;
  logic [31:0] last_paddr_reg;
  logic [31:0] rd_mux;
  logic [31:0] old_word;

  // one wait cycle per access keeps read data registered
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_reg;
  assign wr_take           = i_avs_write & ack_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    unique case (i_avs_address)
      `GMO_OFS_GLOBAL_CTL:  old_word = global_ctl_reg;
      `GMO_OFS_PPROC_CTL:   old_word = pproc_ctl_reg;
      `GMO_OFS_STATUS_PAGE: old_word = status_page_reg;
      `GMO_OFS_RING_START:  old_word = ring_start_reg;
      `GMO_OFS_RING_LEN:    old_word = ring_len_reg;
      `GMO_OFS_BATCH_START: old_word = batch_start_reg;
      `GMO_OFS_BATCH_END:   old_word = batch_end_reg;
      `GMO_OFS_DEPTH_CFG:   old_word = depth_cfg_reg;
      default:              old_word = 32'h0;
    endcase
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = i_avs_byteenable[b] ? i_avs_writedata[8*b +: 8]
                                             : old_word[8*b +: 8];
    end
  end

  // ==========================================================
  // configuration registers
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      global_ctl_reg  <= 32'h0;
      pproc_ctl_reg   <= 32'h0;
      status_page_reg <= 32'h0;
      ring_start_reg  <= 32'h0;
      ring_len_reg    <= 32'h0;
      batch_start_reg <= 32'h0;
      batch_end_reg   <= 32'h0;
      depth_cfg_reg   <= 32'h0;
    end else if (wr_take) begin
      unique case (i_avs_address)
        // low base bits are not kept
        `GMO_OFS_GLOBAL_CTL:  global_ctl_reg  <= wmerge & 32'hffff_f007;
        `GMO_OFS_PPROC_CTL:   pproc_ctl_reg   <= wmerge & 32'hffff_f007;
        `GMO_OFS_STATUS_PAGE: status_page_reg <= wmerge & ~`GMO_PAGE_MASK;
        `GMO_OFS_RING_START:  ring_start_reg  <= wmerge & ~`GMO_PAGE_MASK;
        // ring length saturates at the cap
        `GMO_OFS_RING_LEN:
          ring_len_reg <= (wmerge > `GMO_RING_MAX) ? `GMO_RING_MAX : wmerge;
        `GMO_OFS_BATCH_START: batch_start_reg <= wmerge & ~`GMO_QWORD_MASK;
        `GMO_OFS_BATCH_END:   batch_end_reg   <= wmerge & ~`GMO_QWORD_MASK;
        `GMO_OFS_DEPTH_CFG:   depth_cfg_reg   <= wmerge & 32'h0000_003f;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // configuration and translation error flags
  // ==========================================================
  always_comb begin
    err_set = '0;
    err_clr = '0;
    if (wr_take) begin
      unique case (i_avs_address)
        `GMO_OFS_GLOBAL_CTL: begin
          err_set[`GMO_E_GBASE] = (wmerge[11:3] != 9'h0);
          err_set[`GMO_E_GSIZE] = (wmerge[2:1] == `GMO_SIZE_64K);
        end
        `GMO_OFS_PPROC_CTL:
          err_set[`GMO_E_PBASE] = (wmerge[11:3] != 9'h0);
        `GMO_OFS_STATUS_PAGE:
          err_set[`GMO_E_HWS_ALIGN] = ((wmerge & `GMO_PAGE_MASK) != 32'h0);
        `GMO_OFS_RING_START:
          err_set[`GMO_E_RING_ALIGN] = ((wmerge & `GMO_PAGE_MASK) != 32'h0);
        `GMO_OFS_RING_LEN:
          err_set[`GMO_E_RING_LEN] = (wmerge > `GMO_RING_MAX);
        `GMO_OFS_BATCH_START, `GMO_OFS_BATCH_END:
          err_set[`GMO_E_BATCH_ALIGN] = ((wmerge & `GMO_QWORD_MASK) != 32'h0);
        `GMO_OFS_ERR: err_clr = wmerge[`GMO_ERR_W-1:0];
        default: ;
      endcase
    end
    // depth or stencil test needs a depth buffer and a colour one
    err_set[`GMO_E_NO_DEPTH]  = (depth_cfg_reg[2] | depth_cfg_reg[3]) &
                                ~depth_cfg_reg[4];
    err_set[`GMO_E_NO_COLOUR] = ~depth_cfg_reg[5] &
                                (depth_cfg_reg[2] | depth_cfg_reg[3]);
    err_set[`GMO_E_XLATE]     = o_xl_ack & o_xl_err;
  end

  // write-one-to-clear; a new event in the same cycle survives the clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      err_reg <= '0;
    end else begin
      err_reg <= (err_reg & ~err_clr) | err_set;
    end
  end

  assign o_pipe_ok = depth_cfg_reg[5] &
                     ~(depth_cfg_reg[2] | depth_cfg_reg[3]) | depth_cfg_reg[4]
                     & depth_cfg_reg[5];

  // ==========================================================
  // translation through the selected table
  // ==========================================================
  gmo_xl_if xl ();
  logic       use_pp;
  logic [1:0] size_code;

  // per-process table wins when enabled, sized by its own control
  assign use_pp    = pproc_ctl_reg[0];
  assign size_code = use_pp ? pproc_ctl_reg[2:1] : global_ctl_reg[2:1];
  assign xl.req    = i_xl_req;
  assign xl.laddr  = i_xl_laddr;
  assign xl.base   = use_pp ? pproc_ctl_reg : global_ctl_reg;

  always_comb begin
    unique case (size_code)
      `GMO_SIZE_128K: xl.ap_log2 = `GMO_AP_128M;
      `GMO_SIZE_256K: xl.ap_log2 = `GMO_AP_256M;
      `GMO_SIZE_512K: xl.ap_log2 = `GMO_AP_512M;
      `GMO_SIZE_64K:  xl.ap_log2 = use_pp ? `GMO_AP_64M : `GMO_AP_128M;
    endcase
  end

  assign o_xl_ack    = xl.ack;
  assign o_xl_paddr  = xl.paddr;
  assign o_xl_err    = xl.err;
  assign o_pte_snoop = 1'b0;

  gmo_walk u_walk (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .xl          (xl),
    .o_pte_rd    (o_pte_rd),
    .o_pte_addr  (o_pte_addr),
    .i_pte_wait  (i_pte_wait),
    .i_pte_rdata (i_pte_rdata)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      last_paddr_reg <= 32'h0;
    end else if (xl.ack && !xl.err) begin
      last_paddr_reg <= xl.paddr;
    end
  end

  // ==========================================================
  // batch fetch and status report
  // ==========================================================
  gmo_batch_t batch_state_reg;
  logic       batch_go;
  logic       batch_last;

  assign batch_go   = wr_take && (i_avs_address == `GMO_OFS_CMD) &&
                      i_avs_writedata[0] && (batch_state_reg == GMO_B_IDLE);
  assign batch_last = (o_batch_addr == batch_end_reg);
  assign o_batch_valid = (batch_state_reg == GMO_B_RUN);
  // batch data is treated as main memory
  assign o_batch_snoop = 1'b0;

  // walk whole words up to and including the end word
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      batch_state_reg <= GMO_B_IDLE;
      o_batch_addr    <= 32'h0;
    end else begin
      unique case (batch_state_reg)
        GMO_B_IDLE: if (batch_go) begin
          o_batch_addr    <= batch_start_reg;
          batch_state_reg <= GMO_B_RUN;
        end
        GMO_B_RUN: if (i_batch_ready) begin
          if (batch_last) begin
            batch_state_reg <= GMO_B_IDLE;
          end else begin
            o_batch_addr <= o_batch_addr + `GMO_QWORD_STEP;
          end
        end
      endcase
    end
  end

  // completion reported into the snooped status page
  assign o_hws_snoop = 1'b1;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_hws_wr   <= 1'b0;
      o_hws_addr <= 32'h0;
      o_hws_data <= 32'h0;
    end else if (o_batch_valid && i_batch_ready && batch_last) begin
      o_hws_wr   <= 1'b1;
      o_hws_addr <= {status_page_reg[31:12], `GMO_HWS_BATCH_OFS};
      o_hws_data <= batch_end_reg;
    end else if (!i_hws_wait) begin
      o_hws_wr <= 1'b0;
    end
  end

  // ==========================================================
  // depth decode
  // ==========================================================
  gmo_depth u_depth (
    .i_sys_clk     (i_sys_clk),
    .i_resetn      (i_resetn),
    .i_fmt         (depth_cfg_reg[1:0]),
    .i_word        (i_depth_word),
    .o_depth       (o_depth),
    .o_is_float    (o_depth_is_float),
    .o_stencil     (o_stencil),
    .o_has_stencil (o_has_stencil)
  );

  // ==========================================================
  // read back
  // ==========================================================
  always_comb begin
    unique case (i_avs_address)
      `GMO_OFS_ERR:        rd_mux = {{(32-`GMO_ERR_W){1'b0}}, err_reg};
      `GMO_OFS_STATE:      rd_mux = {29'h0, o_hws_wr, ~xl.ack & o_pte_rd,
                                     o_batch_valid};
      `GMO_OFS_LAST_PADDR: rd_mux = last_paddr_reg;
      default:             rd_mux = old_word;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack_reg) begin
      o_avs_readdata <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  ring_len_cap_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ring_len_reg <= `GMO_RING_MAX)
    else $error("ring length above cap");
  ring_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (wr_take && i_avs_address == `GMO_OFS_RING_START &&
     (wmerge & `GMO_PAGE_MASK) != 32'h0) |=> err_reg[`GMO_E_RING_ALIGN])
    else $error("ring misalignment not flagged");
  batch_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_batch_valid && i_batch_ready && batch_last) |=> !o_batch_valid)
    else $error("batch fetch ran past end word");
  batch_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_batch_valid && i_batch_ready && !batch_last) |=>
      (o_batch_valid && o_batch_addr == $past(o_batch_addr) + `GMO_QWORD_STEP))
    else $error("batch address step wrong");
  hws_page_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_hws_wr) |-> (o_hws_addr[11:0] == `GMO_HWS_BATCH_OFS &&
      o_hws_addr[31:12] == status_page_reg[31:12] && o_hws_snoop))
    else $error("status write outside page");
  depth_guard_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (depth_cfg_reg[2] && !depth_cfg_reg[4]) |=> err_reg[`GMO_E_NO_DEPTH])
    else $error("depth test without buffer not flagged");
  bus_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (req && !ack_reg) |-> o_avs_waitrequest ##1 (req -> !o_avs_waitrequest))
    else $error("waitrequest timing wrong");
  xlate_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_xl_req && !o_pte_rd && !o_xl_ack &&
     (i_xl_laddr >> xl.ap_log2) != 32'h0) |=> (o_xl_ack && o_xl_err))
    else $error("out-of-aperture address not refused");
endmodule
`default_nettype wire

// ===== design/gmo_walk.sv
// page translation entry walker
`timescale 1ns/1ps
`default_nettype none
`include "gmo_defines.svh"
module gmo_walk import gmo_pkg::*; (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // request path
  gmo_xl_if.walk           xl,
  // entry fetch from non-snooped memory
  output logic             o_pte_rd,
  output logic [31:0]      o_pte_addr,
  input  wire logic        i_pte_wait,
  input  wire logic [31:0] i_pte_rdata
);
  gmo_walk_t   state_reg;
  logic [31:0] paddr_reg;
  logic        err_reg;
  logic        range_bad;

  assign range_bad = (xl.laddr >> xl.ap_log2) != 32'h0;
  assign o_pte_rd  = (state_reg == GMO_W_READ);
  assign xl.ack    = (state_reg == GMO_W_RESP);
  assign xl.paddr  = paddr_reg;
  assign xl.err    = err_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_reg  <= GMO_W_IDLE;
      o_pte_addr <= 32'h0;
      paddr_reg  <= 32'h0;
      err_reg    <= 1'b0;
    end else begin
      unique case (state_reg)
        GMO_W_IDLE: if (xl.req) begin
          err_reg <= range_bad;
          o_pte_addr <= (xl.base & ~`GMO_PAGE_MASK) +
                        {10'h0, xl.laddr[31:12], 2'b00};
          state_reg <= range_bad ? GMO_W_RESP : GMO_W_READ;
        end
        GMO_W_READ: if (!i_pte_wait) begin
          // frame plus offset; bit 0 marks a valid entry
          paddr_reg <= {i_pte_rdata[31:12], xl.laddr[11:0]};
          err_reg   <= ~i_pte_rdata[0];
          state_reg <= GMO_W_RESP;
        end
        GMO_W_RESP: state_reg <= GMO_W_IDLE;
      endcase
    end
  end

  compose_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_pte_rd && !i_pte_wait && i_pte_rdata[0]) |=>
      (xl.ack && xl.paddr[11:0] == $past(xl.laddr[11:0]) &&
       xl.paddr[31:12] == $past(i_pte_rdata[31:12])))
    else $error("translated address wrong");
endmodule
`default_nettype wire

// ===== dv/gmo_mem_model.sv
// system memory model serving entry, batch and status traffic
`timescale 1ns/1ps
`default_nettype none
module gmo_mem_model (
  // clock, reset and entry request
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        o_pte_rd,
  input  wire logic [31:0] o_pte_addr,
  // answers
  output logic             i_pte_wait,
  output logic [31:0]      i_pte_rdata,
  output logic             i_batch_ready,
  output logic             i_hws_wait
);
  logic [1:0] cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    cnt_reg <= i_resetn ? cnt_reg + 2'h1 : 2'h0;
  end
  // stalls vary so prompt and slow answers both occur
  assign i_pte_wait    = cnt_reg != 2'h3;
  assign i_batch_ready = cnt_reg[0];
  assign i_hws_wait    = cnt_reg == 2'h0;
  // tables sit 4KB aligned in non-snooped memory
  // rings and batches are placed aligned and linear
  // no surfaces are held in this model
  // entry slot 5 invalid; a released bus toggles
  assign i_pte_rdata = o_pte_rd ?
    {o_pte_addr[21:2] + 20'h00040, 11'h0, o_pte_addr[4:2] != 3'h5} :
    {32{cnt_reg[0]}};
endmodule
`default_nettype wire

// ===== dv/gmo_top_test.sv
// self-checking bench for the memory object block
`timescale 1ns/1ps
`default_nettype none
module gmo_top_test;
  logic i_sys_clk = 0, i_resetn = 0, i_avs_read = 0, i_avs_write = 0;
  logic i_xl_req = 0, o_avs_waitrequest, o_xl_ack, o_xl_err, o_pte_rd;
  logic o_pte_snoop, i_pte_wait, o_batch_valid, o_batch_snoop, hws_seen;
  logic i_batch_ready, o_hws_wr, o_hws_snoop, i_hws_wait, o_pipe_ok;
  logic o_depth_is_float, o_has_stencil;
  logic [5:0]  i_avs_address = 0;
  logic [7:0]  o_stencil;
  logic [63:0] i_depth_word = 64'h8899aabbc0c1c2c3;
  logic [31:0] i_avs_writedata = 0, i_xl_laddr = 0, o_avs_readdata;
  logic [31:0] o_xl_paddr, o_pte_addr, o_batch_addr, o_hws_addr, i_pte_rdata;
  logic [31:0] o_hws_data, o_depth, rdv, last_a, hws_a, hws_d;
  int fail_count = 0, check_count = 0, nw;
  logic [5:0]  mo[6] = '{6'h00, 6'h04, 6'h0c, 6'h10, 6'h14, 6'h08};
  logic [31:0] md[6] = '{32'h00100800, 32'h00200801, 32'h00001004,
                         32'h00300000, 32'h00008004, 32'h00030010};
  logic [31:0] dd[4] = '{32'hc0c1c2c3, 32'hc0c1c2c3, 32'h00c1c2c3,
                         32'h0000c2c3};
  logic [9:0]  de[4] = '{10'h388, 10'h200, 10'h1c0, 10'h000};
  gmo_top DUT (.i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hf),
    .o_avs_readdata, .o_avs_waitrequest, .i_xl_req, .i_xl_laddr, .o_xl_ack,
    .o_xl_paddr, .o_xl_err, .o_pte_rd, .o_pte_addr, .o_pte_snoop,
    .i_pte_wait, .i_pte_rdata, .o_batch_valid, .o_batch_addr,
    .o_batch_snoop, .i_batch_ready, .o_hws_wr, .o_hws_addr, .o_hws_data,
    .o_hws_snoop, .i_hws_wait, .i_depth_word, .o_depth, .o_depth_is_float,
    .o_stencil, .o_has_stencil, .o_pipe_ok);
  gmo_mem_model MEM (.i_sys_clk, .i_resetn, .o_pte_rd, .o_pte_addr,
    .i_pte_wait, .i_pte_rdata, .i_batch_ready, .i_hws_wait);
  // ==========================================================
  // clock, monitors and closing
  initial forever #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (o_batch_valid && i_batch_ready) begin
      nw = nw + 1;
      last_a = o_batch_addr;
    end
    if (o_hws_wr && !i_hws_wait) begin
      hws_seen = 1;
      hws_a = o_hws_addr;
      hws_d = o_hws_data;
    end
  end
  task end_of_test;
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fail_count++;
    end_of_test;
  end
  // ==========================================================
  // access tasks
  task chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // request held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rdv = o_avs_readdata;
    i_avs_write <= 0;
    i_avs_read <= 0;
    if (n >= 50) fail_count++;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask
  task rc(input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(rdv, e);
  endtask
  function automatic logic [31:0] pa(input logic [31:0] b, l);
    logic [31:0] e;
    e = {b[31:12], 12'h0} + {l[31:12], 2'h0};
    return {e[21:2] + 20'h00040, l[11:0]};
  endfunction
  task xl(input logic [31:0] a, p, input logic e);
    int n;
    @(posedge i_sys_clk);
    i_xl_req <= 1;
    i_xl_laddr <= a;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_xl_ack !== 1'b1 && n < 50);
    i_xl_req <= 0;
    chk({31'h0, o_xl_err}, {31'h0, e});
    if (!e) chk(o_xl_paddr, p);
  endtask
  task bt(input logic [31:0] s, e, input int n);
    int k;
    wr(6'h14, s);
    wr(6'h18, e);
    nw = 0;
    hws_seen = 0;
    wr(6'h28, 32'h1);
    k = 0;
    while (!hws_seen && k < 300) begin
      @(posedge i_sys_clk);
      k++;
    end
    chk(nw, n);
    chk(last_a, e);
    chk({hws_a, hws_d} == {32'h00030010, e}, 1);
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_resetn <= 1;
    rc(6'h20, 32'h0);
    rc(6'h3c, 32'h0);
    for (int s = 0; s < 3; s++) begin
      wr(6'h00, 32'h00100000 | 32'(s << 1));
      xl((32'h08000000 << s) - 32'h1000,
         pa(32'h00100000, (32'h08000000 << s) - 32'h1000), 0);
      xl(32'h08000000 << s, 32'h0, 1);
    end
    xl(32'h00005000, 32'h0, 1);
    rc(6'h20, 32'h200);
    wr(6'h04, 32'h00200007);
    xl(32'h03fff000, pa(32'h00200000, 32'h03fff000), 0);
    xl(32'h04000000, 32'h0, 1);
    rc(6'h2c, pa(32'h00200000, 32'h03fff000));
    rc(6'h24, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(6'h20, 32'h3ff);
      wr(mo[i], md[i]);
      rc(6'h20, 32'h1 << i);
    end
    rc(6'h10, 32'h00200000);
    bt(32'h00008000, 32'h00008018, 4);
    bt(32'hfffffff8, 32'h00000000, 2);
    chk({o_batch_snoop, o_pte_snoop, o_hws_snoop}, 3'h1);
    for (int f = 0; f < 4; f++) begin
      wr(6'h1c, 32'h30 | 32'(f));
      repeat (2) @(posedge i_sys_clk);
      chk(o_depth, dd[f]);
      chk({o_depth_is_float, o_has_stencil,
           o_has_stencil ? o_stencil : 8'h0}, de[f]);
    end
    wr(6'h20, 32'h3ff);
    wr(6'h1c, 32'h24);
    rc(6'h20, 32'h80);
    chk({31'h0, o_pipe_ok}, 32'h0);
    wr(6'h1c, 32'h34);
    wr(6'h20, 32'h3ff);
    rc(6'h20, 32'h0);
    chk({31'h0, o_pipe_ok}, 32'h1);
    wr(6'h1c, 32'h14);
    rc(6'h20, 32'h100);
    chk({31'h0, o_pipe_ok}, 32'h0);
    end_of_test;
  end
endmodule
`default_nettype wire

// ===== pkg/gmo_defines.svh
// constants for the graphics memory object block
`ifndef GMO_DEFINES_SVH
`define GMO_DEFINES_SVH
// register byte offsets
`define GMO_OFS_GLOBAL_CTL  6'h00
`define GMO_OFS_PPROC_CTL   6'h04
`define GMO_OFS_STATUS_PAGE 6'h08
`define GMO_OFS_RING_START  6'h0c
`define GMO_OFS_RING_LEN    6'h10
`define GMO_OFS_BATCH_START 6'h14
`define GMO_OFS_BATCH_END   6'h18
`define GMO_OFS_DEPTH_CFG   6'h1c
`define GMO_OFS_ERR         6'h20
`define GMO_OFS_STATE       6'h24
`define GMO_OFS_CMD         6'h28
`define GMO_OFS_LAST_PADDR  6'h2c
// alignment masks, ring cap, batch step and status offset
`define GMO_PAGE_MASK       32'h0000_0fff
`define GMO_QWORD_MASK      32'h0000_0007
`define GMO_RING_MAX        32'h0020_0000
`define GMO_QWORD_STEP      32'h0000_0008
`define GMO_HWS_BATCH_OFS   12'h010
// table size codes and aperture widths
`define GMO_SIZE_128K       2'h0
`define GMO_SIZE_256K       2'h1
`define GMO_SIZE_512K       2'h2
`define GMO_SIZE_64K        2'h3
`define GMO_AP_64M          5'h1a
`define GMO_AP_128M         5'h1b
`define GMO_AP_256M         5'h1c
`define GMO_AP_512M         5'h1d
// depth formats
`define GMO_DF_F32_S8_64    2'h0
`define GMO_DF_F32          2'h1
`define GMO_DF_U24_S8       2'h2
`define GMO_DF_U16          2'h3
// error bits
`define GMO_E_GBASE         0
`define GMO_E_PBASE         1
`define GMO_E_RING_ALIGN    2
`define GMO_E_RING_LEN      3
`define GMO_E_BATCH_ALIGN   4
`define GMO_E_HWS_ALIGN     5
`define GMO_E_GSIZE         6
`define GMO_E_NO_DEPTH      7
`define GMO_E_NO_COLOUR     8
`define GMO_E_XLATE         9
`define GMO_ERR_W           10
`endif

// ===== pkg/gmo_pkg.sv
// types shared by the graphics memory object block
package gmo_pkg;
  typedef enum logic [1:0] {GMO_W_IDLE, GMO_W_READ, GMO_W_RESP} gmo_walk_t;
  typedef enum logic {GMO_B_IDLE, GMO_B_RUN} gmo_batch_t;
endpackage

// ===== pkg/gmo_xl_if.sv
// translation request path between top and table walker
`timescale 1ns/1ps
`default_nettype none
interface gmo_xl_if;
  logic        req;
  logic [31:0] laddr;
  logic [31:0] base;
  logic [4:0]  ap_log2;
  logic        ack;
  logic [31:0] paddr;
  logic        err;
  modport top (output req, laddr, base, ap_log2, input ack, paddr, err);
  modport walk (input req, laddr, base, ap_log2, output ack, paddr, err);
endinterface
`default_nettype wire
